/* File: rtl/hipm_pkg.sv */
// shared constants for the host pin interface: config bits, indices, timing
// assumes a 100 MHz mclk on both ends
`default_nettype none
package hipm_pkg;
	// ============================================================
	// widths
	localparam int DW      = 8;
	localparam int AW      = 12;
	localparam int NDMA    = 4;
	localparam int NIRQ    = 8;
	// ============================================================
	// configuration register indices, decoded from addr[3:0]
	localparam logic [3:0] REG_PIN_FN  = 4'h0;
	localparam logic [3:0] REG_IRQ_MD  = 4'h1;
	localparam logic [3:0] REG_CLK_CFG = 4'h2;
	localparam logic [3:0] REG_PNP_IRQ = 4'h3;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [10:0] CFG_BASE_RST = 11'h250;
	localparam logic       CFG_BASE_A11 = 1'b0;
	// ============================================================
	// field positions
	localparam int WIDE_DECODE_BIT    = 6;
	localparam int PRINTER_DETECT_BIT = 7;
	localparam int IRQ_GPIO_BIT       = 4;
	localparam int SERIAL_IRQ_BIT     = 2;
	localparam int REF_CLK_BIT        = 0;
	localparam int ACPI_ON_A_BIT      = 0;
	// ============================================================
	// reset values
	localparam logic [7:0] PIN_FN_RST  = 8'h00;
	localparam logic [7:0] IRQ_MD_RST  = 8'h00;
	localparam logic [7:0] CLK_CFG_RST = 8'h00;
	localparam logic [7:0] PNP_IRQ_RST = 8'h00;
	// ============================================================
	// timing
	localparam int CLK_NS      = 10;
	localparam int SETUP_NS    = 40;
	localparam int STROBE_NS   = 120;
	localparam int HOLD_NS     = 60;
	localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PCI_HALF    = 4;
	localparam int SIRQ_SLOTS  = 9;
	typedef enum logic [1:0] {HIPM_IDLE, HIPM_SETUP, HIPM_STROBE, HIPM_HOLD} hipm_state_t;
endpackage
`default_nettype wire

/* File: rtl/hipm_if.sv */
// pins between the host chipset and the device
// both ends run on mclk; the wire levels are resolved here from the enables
`default_nettype none
interface hipm_if;
	logic                    master_reset_in;
	logic                    cs_n;
	logic                    aen;
	logic                    ior_n;
	logic                    iow_n;
	logic [hipm_pkg::AW-1:0] addr;
	logic [hipm_pkg::DW-1:0] hd_o;
	logic                    hd_oe;
	logic [hipm_pkg::DW-1:0] dd_o;
	logic                    dd_oe;
	logic [hipm_pkg::DW-1:0] data_lvl;
	logic                    chrdy_oe;
	logic                    chrdy_lvl;
	logic [3:0]              drq;
	logic [3:0]              dack_n;
	logic                    tc;
	logic [1:0]              pin_ab_o;
	logic [1:0]              pin_ab_oe;
	logic [1:0]              pin_ab_lvl;
	logic [4:0]              irq_cg;
	logic                    pin_h;
	logic                    pci_clk;
	// ============================================================
	// wire resolution; an undriven data bus or ready line floats high, an undriven pin A or B reads low
	assign data_lvl   = hd_oe ? hd_o : (dd_oe ? dd_o : 8'hFF);
	assign chrdy_lvl  = ~chrdy_oe;
	assign pin_ab_lvl = (pin_ab_o & pin_ab_oe);
	modport dev (input master_reset_in, cs_n, aen, ior_n, iow_n, addr, data_lvl, dack_n, tc, pin_ab_lvl, pci_clk,
		output dd_o, dd_oe, chrdy_oe, drq, pin_ab_o, pin_ab_oe, irq_cg, pin_h);
	modport host (output master_reset_in, cs_n, aen, ior_n, iow_n, addr, hd_o, hd_oe, dack_n, tc, pci_clk,
		input data_lvl, chrdy_lvl, drq, pin_ab_lvl, irq_cg, pin_h);
endinterface
`default_nettype wire

/* File: rtl/hipm_dev.sv */
// device end of the host pin interface: decode, config registers, pin muxing
// assumes all bus pins arrive asynchronously and are filtered on mclk
// What this block does
// - master reset input is active high
// - respond only while chip select low
// - eight-bit two-way data bus
// - address bits 0-10 used for decode
// - address bit 11 used only when bit6 clear
// - epp mode stretches cycle via channel ready
// - four dma request/acknowledge pairs A to D
// - terminal count ends the active transfer
// - detect 1 selects printer, 0 floppy
// - printer detect enabled by config bit7
// - select bit turns irq A/B into gpio
// - acpi interrupt may appear on pin A
// - irq C-G dedicated, external irq input
// - fast ir pin direction set by ir register
// - ir module select 1 and 2 outputs
// - pci clock drives serial irq logic only
// - mode bit2 puts serial irq on pin H
// - clock select bit matches reference clock
`default_nettype none
module hipm_dev #(
	parameter logic [10:0] CFG_BASE = hipm_pkg::CFG_BASE_RST
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	hipm_if.dev             bus,
	output logic            device_reset,
	input  wire logic       epp_mode,
	input  wire logic       epp_busy,
	input  wire logic [3:0] dma_req,
	output logic      [3:0] dma_ack,
	output logic      [3:0] dma_done,
	input  wire logic       printer_detect_in,
	output logic            route_to_printer,
	input  wire logic [7:0] irq_src,
	input  wire logic       acpi_irq,
	input  wire logic       external_irq_in,
	output logic            external_irq_seen,
	input  wire logic [1:0] gpio_out,
	input  wire logic [1:0] gpio_oe,
	output logic      [1:0] gpio_in,
	input  wire logic       fast_ir_dir_out,
	input  wire logic       fast_ir_sel0,
	input  wire logic       fast_ir_pin_i,
	output logic            fast_ir_pin_o,
	output logic            fast_ir_pin_oe,
	output logic            fast_ir_rx,
	input  wire logic       ir_sel1,
	input  wire logic       ir_sel2,
	output logic            ir_module_select1,
	output logic            ir_module_select2,
	output logic            ref_clock_select,
	output logic            serial_irq_mode
);
	// ============================================================
	// input filter: three flops, a bit moves once stages two and three agree
	localparam int SW = 36;
	logic [SW-1:0] raw;
	logic [SW-1:0] s1_q;
	logic [SW-1:0] s2_q;
	logic [SW-1:0] s3_q;
	logic [SW-1:0] f_q;
	// idle pin levels, so that no false edge or acknowledge follows reset
	localparam logic [SW-1:0] IDLE = {1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 12'h000, 8'hFF, 4'hF, 1'b0, 1'b0, 2'h0, 1'b1,
		1'b0, 1'b0};
	assign raw = {bus.master_reset_in, bus.cs_n, bus.aen, bus.ior_n, bus.iow_n, bus.addr, bus.data_lvl,
		bus.dack_n, bus.tc, bus.pci_clk, bus.pin_ab_lvl, printer_detect_in, external_irq_in, fast_ir_pin_i};
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_q <= IDLE;
			s2_q <= IDLE;
			s3_q <= IDLE;
			f_q  <= IDLE;
		end else if (clk_en) begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
		end
	end
	wire        mr_f      = f_q[35];
	wire        cs_f_n    = f_q[34];
	wire        aen_f     = f_q[33];
	wire        ior_f_n   = f_q[32];
	wire        iow_f_n   = f_q[31];
	wire [11:0] addr_f    = f_q[30:19];
	wire [7:0]  data_f    = f_q[18:11];
	wire [3:0]  dack_f_n  = f_q[10:7];
	wire        tc_f      = f_q[6];
	wire        pci_f     = f_q[5];
	wire [1:0]  ab_f      = f_q[4:3];
	wire        pnf_f     = f_q[2];
	wire        ext_irq_f = f_q[1];
	wire        ir_rx_f   = f_q[0];
	// ============================================================
	// configuration registers
	logic [7:0] pin_fn_q;
	logic [7:0] irq_md_q;
	logic [7:0] clk_cfg_q;
	logic [7:0] pnp_irq_q;
	wire  cfg_rst = !rst_n || mr_f;
	// ============================================================
	// address decode
	wire wide_dec = ~pin_fn_q[hipm_pkg::WIDE_DECODE_BIT];
	wire a11_ok   = !wide_dec || (addr_f[11] == hipm_pkg::CFG_BASE_A11);
	wire base_ok  = (addr_f[10:4] == CFG_BASE[10:4]);
	wire sel      = !cs_f_n && !aen_f && base_ok && a11_ok;
	wire rd_act   = sel && !ior_f_n;
	wire wr_act   = sel && !iow_f_n;
	wire [3:0] idx = addr_f[3:0];
	// ============================================================
	// write: latch while the strobe is low, commit when it rises
	logic       wr_pend_q;
	logic [3:0] wr_idx_q;
	logic [7:0] wr_dat_q;
	wire        wr_commit = wr_pend_q && iow_f_n;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 4'h0;
			wr_dat_q  <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= wr_act;
			if (wr_act) begin
				wr_idx_q <= idx;
				wr_dat_q <= data_f;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (cfg_rst) begin
			pin_fn_q  <= hipm_pkg::PIN_FN_RST;
			irq_md_q  <= hipm_pkg::IRQ_MD_RST;
			clk_cfg_q <= hipm_pkg::CLK_CFG_RST;
			pnp_irq_q <= hipm_pkg::PNP_IRQ_RST;
		end else if (clk_en && wr_commit) begin
			if (wr_idx_q == hipm_pkg::REG_PIN_FN)
				pin_fn_q <= wr_dat_q;
			if (wr_idx_q == hipm_pkg::REG_IRQ_MD)
				irq_md_q <= wr_dat_q;
			if (wr_idx_q == hipm_pkg::REG_CLK_CFG)
				clk_cfg_q <= wr_dat_q;
			if (wr_idx_q == hipm_pkg::REG_PNP_IRQ)
				pnp_irq_q <= wr_dat_q;
		end
	end
	// ============================================================
	// read data
	logic [3:0] drq_q;
	wire [7:0] status = {route_to_printer, ext_irq_f, ab_f, drq_q};
	wire [7:0] rd_mux = (idx == hipm_pkg::REG_PIN_FN)  ? pin_fn_q  :
	                    (idx == hipm_pkg::REG_IRQ_MD)  ? irq_md_q  :
	                    (idx == hipm_pkg::REG_CLK_CFG) ? clk_cfg_q :
	                    (idx == hipm_pkg::REG_PNP_IRQ) ? pnp_irq_q :
	                    (idx == hipm_pkg::REG_STATUS)  ? status    : 8'h00;
	logic [7:0] dd_q;
	logic       dd_oe_q;
	logic       chrdy_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dd_q    <= 8'h00;
			dd_oe_q <= 1'b0;
			chrdy_q <= 1'b0;
		end else if (clk_en) begin
			dd_oe_q <= rd_act && !cfg_rst;
			dd_q    <= rd_mux;
			chrdy_q <= (rd_act || wr_act) && epp_mode && epp_busy;
		end
	end
	assign bus.dd_o     = dd_q;
	assign bus.dd_oe    = dd_oe_q;
	assign bus.chrdy_oe = chrdy_q;
	// ============================================================
	// dma channels A to D
	logic [3:0] end_q;
	logic [3:0] done_q;
	wire  [3:0] dack_on = ~dack_f_n;
	wire  [3:0] tc_hit  = dack_on & {4{tc_f}};
	always_ff @(posedge mclk) begin
		if (cfg_rst) begin
			drq_q  <= 4'h0;
			end_q  <= 4'h0;
			done_q <= 4'h0;
		end else if (clk_en) begin
			end_q  <= (end_q | tc_hit) & dma_req;
			done_q <= tc_hit & ~end_q;
			drq_q  <= dma_req & ~end_q & ~tc_hit;
		end
	end
	assign bus.drq  = drq_q;
	assign dma_ack  = dack_on;
	assign dma_done = done_q;
	// ============================================================
	// serial interrupt frame, advanced on filtered pci clock rises
	logic       pci_prev_q;
	logic [3:0] slot_q;
	logic       sirq_q;
	wire        sirq_on  = irq_md_q[hipm_pkg::SERIAL_IRQ_BIT];
	wire        pci_rise = pci_f && !pci_prev_q;
	wire [8:0]  frame    = {irq_src, 1'b1};
	always_ff @(posedge mclk) begin
		if (cfg_rst) begin
			pci_prev_q <= 1'b0;
			slot_q     <= 4'h0;
			sirq_q     <= 1'b1;
		end else if (clk_en) begin
			pci_prev_q <= pci_f;
			if (sirq_on && pci_rise) begin
				sirq_q <= ~frame[slot_q];
				slot_q <= (slot_q == 4'(hipm_pkg::SIRQ_SLOTS - 1)) ? 4'h0 : slot_q + 4'h1;
			end else if (!sirq_on) begin
				slot_q <= 4'h0;
				sirq_q <= 1'b1;
			end
		end
	end
	// ============================================================
	// interrupt and gpio pin muxing
	logic [1:0] ab_q;
	logic [1:0] ab_oe_q;
	logic [4:0] cg_q;
	logic       h_q;
	wire gpio_sel = pin_fn_q[hipm_pkg::IRQ_GPIO_BIT];
	wire acpi_a   = pnp_irq_q[hipm_pkg::ACPI_ON_A_BIT];
	wire irq_a    = acpi_a ? acpi_irq : irq_src[0];
	always_ff @(posedge mclk) begin
		if (cfg_rst) begin
			ab_q    <= 2'b00;
			ab_oe_q <= 2'b00;
			cg_q    <= 5'h00;
			h_q     <= 1'b0;
		end else if (clk_en) begin
			ab_q    <= gpio_sel ? {gpio_out[0], gpio_out[1]} : {irq_src[1], irq_a};
			ab_oe_q <= gpio_sel ? {gpio_oe[0], gpio_oe[1]} : 2'b11;
			cg_q    <= irq_src[6:2];
			h_q     <= sirq_on ? sirq_q : irq_src[7];
		end
	end
	// pin A is gpio one, pin B is gpio zero
	assign bus.pin_ab_o  = {ab_q[1], ab_q[0]} & 2'b11;
	assign bus.pin_ab_oe = ab_oe_q;
	assign bus.irq_cg    = cg_q;
	assign bus.pin_h     = h_q;
	assign gpio_in       = {ab_f[0], ab_f[1]};
	assign external_irq_seen = ext_irq_f;
	// ============================================================
	// printer detect, ir pins, clock select
	logic prn_q;
	logic ir_o_q;
	logic ir_oe_q;
	logic sl1_q;
	logic sl2_q;
	always_ff @(posedge mclk) begin
		if (cfg_rst) begin
			prn_q   <= 1'b1;
			ir_o_q  <= 1'b0;
			ir_oe_q <= 1'b0;
			sl1_q   <= 1'b0;
			sl2_q   <= 1'b0;
		end else if (clk_en) begin
			prn_q   <= pin_fn_q[hipm_pkg::PRINTER_DETECT_BIT] ? pnf_f : 1'b1;
			ir_oe_q <= fast_ir_dir_out;
			ir_o_q  <= fast_ir_sel0;
			sl1_q   <= ir_sel1;
			sl2_q   <= ir_sel2;
		end
	end
	assign route_to_printer  = prn_q;
	assign fast_ir_pin_o     = ir_o_q;
	assign fast_ir_pin_oe    = ir_oe_q;
	assign fast_ir_rx        = ir_oe_q ? 1'b0 : ir_rx_f;
	assign ir_module_select1 = sl1_q;
	assign ir_module_select2 = sl2_q;
	assign ref_clock_select  = clk_cfg_q[hipm_pkg::REF_CLK_BIT];
	assign serial_irq_mode   = sirq_on;
	assign device_reset      = mr_f;
endmodule
`default_nettype wire

/* File: rtl/hipm_host.sv */
// host chipset end: i/o cycles, dma acknowledge with terminal count, pci clock
// assumes device pins arrive asynchronously; each is filtered over three flops
`default_nettype none
module hipm_host #(
	parameter int DMA_LEN = 4
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	hipm_if.host             bus,
	input  wire logic        reset_device,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [11:0] cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	output logic             cmd_ready,
	output logic             rsp_valid,
	output logic      [7:0]  rsp_rdata,
	input  wire logic [3:0]  dma_enable,
	output logic      [3:0]  dma_tc_sent,
	output logic      [9:0]  irq_level
);
	// ============================================================
	// input filter
	logic [22:0] s1_q;
	logic [22:0] s2_q;
	logic [22:0] s3_q;
	logic [22:0] f_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q  <= '0;
		end else if (clk_en) begin
			s1_q <= {bus.chrdy_lvl, bus.data_lvl, bus.drq, bus.pin_ab_lvl, bus.irq_cg, bus.pin_h, bus.pin_h, 1'b0};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
		end
	end
	wire       rdy_f  = f_q[22];
	wire [7:0] data_f = f_q[21:14];
	wire [3:0] drq_f  = f_q[13:10];
	assign irq_level = f_q[9:0];
	// ============================================================
	// cycle sequencer
	hipm_pkg::hipm_state_t st_q;
	logic [7:0]  cnt_q;
	logic        is_dma_q;
	logic        wr_q;
	logic [3:0]  ch_q;
	logic [15:0] xfer_q;
	logic        last_q;
	logic [3:0]  tc_sent_q;
	logic [7:0]  rd_q;
	logic        rv_q;
	wire  [3:0]  want  = drq_f & dma_enable;
	wire  [3:0]  grant = want & (~want + 4'h1);
	wire         idle  = (st_q == hipm_pkg::HIPM_IDLE);
	wire [1:0]   ch_ix = grant[1] ? 2'd1 : grant[2] ? 2'd2 : grant[3] ? 2'd3 : 2'd0;
	wire         tc_now = (xfer_q[4*ch_ix +: 4] == 4'(DMA_LEN - 1));
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q      <= hipm_pkg::HIPM_IDLE;
			cnt_q     <= 8'h00;
			is_dma_q  <= 1'b0;
			wr_q      <= 1'b0;
			ch_q      <= 4'h0;
			xfer_q    <= 16'h0000;
			last_q    <= 1'b0;
			tc_sent_q <= 4'h0;
			rd_q      <= 8'h00;
			rv_q      <= 1'b0;
		end else if (clk_en) begin
			rv_q      <= 1'b0;
			tc_sent_q <= 4'h0;
			cnt_q     <= cnt_q + 8'h01;
			unique case (st_q)
				hipm_pkg::HIPM_IDLE: begin
					cnt_q <= 8'h00;
					if (|grant) begin
						st_q     <= hipm_pkg::HIPM_SETUP;
						is_dma_q <= 1'b1;
						wr_q     <= 1'b0;
						ch_q     <= grant;
						last_q   <= tc_now;
						xfer_q[4*ch_ix +: 4] <= tc_now ? 4'h0 : xfer_q[4*ch_ix +: 4] + 4'h1;
					end else if (cmd_valid) begin
						st_q     <= hipm_pkg::HIPM_SETUP;
						is_dma_q <= 1'b0;
						wr_q     <= cmd_write;
						ch_q     <= 4'h0;
						last_q   <= 1'b0;
					end
				end
				hipm_pkg::HIPM_SETUP: begin
					if (cnt_q == 8'(hipm_pkg::SETUP_CYC - 1)) begin
						st_q  <= hipm_pkg::HIPM_STROBE;
						cnt_q <= 8'h00;
					end
				end
				hipm_pkg::HIPM_STROBE: begin
					if (cnt_q >= 8'(hipm_pkg::STROBE_CYC - 1)) begin
						cnt_q <= cnt_q;
						if (rdy_f) begin
							st_q  <= hipm_pkg::HIPM_HOLD;
							cnt_q <= 8'h00;
							rd_q  <= data_f;
							rv_q  <= !wr_q && !is_dma_q;
							if (last_q)
								tc_sent_q <= ch_q;
						end
					end
				end
				hipm_pkg::HIPM_HOLD: begin
					if (cnt_q == 8'(hipm_pkg::HOLD_CYC - 1))
						st_q <= hipm_pkg::HIPM_IDLE;
				end
			endcase
		end
	end
	assign cmd_ready   = idle && !(|grant);
	assign rsp_valid   = rv_q;
	assign rsp_rdata   = rd_q;
	assign dma_tc_sent = tc_sent_q;
	// ============================================================
	// bus drive; address and write data are held for the whole cycle
	logic [11:0] addr_q;
	logic [7:0]  wd_q;
	logic        pci_q;
	logic [2:0]  pdiv_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_q <= 12'h000;
			wd_q   <= 8'h00;
			pci_q  <= 1'b0;
			pdiv_q <= 3'h0;
		end else if (clk_en) begin
			if (idle && cmd_valid && !(|grant)) begin
				addr_q <= cmd_addr;
				wd_q   <= cmd_wdata;
			end
			pdiv_q <= (pdiv_q == 3'(hipm_pkg::PCI_HALF - 1)) ? 3'h0 : pdiv_q + 3'h1;
			if (pdiv_q == 3'(hipm_pkg::PCI_HALF - 1))
				pci_q <= ~pci_q;
		end
	end
	wire busy   = !idle;
	wire strobe = (st_q == hipm_pkg::HIPM_STROBE);
	assign bus.master_reset_in = reset_device;
	assign bus.cs_n   = !(busy && !is_dma_q);
	assign bus.aen    = busy && is_dma_q;
	assign bus.ior_n  = !(strobe && !wr_q);
	assign bus.iow_n  = !(strobe && wr_q);
	assign bus.addr   = addr_q;
	assign bus.hd_o   = wd_q;
	assign bus.hd_oe  = busy && wr_q && !is_dma_q;
	assign bus.dack_n = ~(is_dma_q && busy ? ch_q : 4'h0);
	assign bus.tc     = is_dma_q && strobe && last_q;
	assign bus.pci_clk = pci_q;
endmodule
`default_nettype wire

/* File: bench/hipm_sva.sv */
// ============================================================
// checker on the wires between the host end and the device end
// assumes one mclk domain and the synchronous active-low rst_n
`default_nettype none
module hipm_sva (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        master_reset_in,
	input wire logic        cs_n,
	input wire logic        aen,
	input wire logic        ior_n,
	input wire logic        iow_n,
	input wire logic [11:0] addr,
	input wire logic        hd_oe,
	input wire logic        dd_oe,
	input wire logic        chrdy_oe,
	input wire logic [3:0]  drq,
	input wire logic [3:0]  dack_n,
	input wire logic        tc
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ============================================================
	// assertions
	property p_unsel_quiet; cs_n [*5] |-> !dd_oe; endproperty
	a_unsel_quiet:
	assert property (p_unsel_quiet) else $error("device drives data while unselected");
	property p_aen_quiet; aen [*5] |-> !dd_oe; endproperty
	a_aen_quiet:
	assert property (p_aen_quiet) else $error("device answers a read during a dma cycle");
	property p_off_base; (addr[10:4] != 7'h25) [*5] |-> !dd_oe; endproperty
	a_off_base:
	assert property (p_off_base) else $error("device answers an address off its base");
	property p_one_driver; !(dd_oe && hd_oe); endproperty
	a_one_driver:
	assert property (p_one_driver) else $error("both ends drive the data bus");
	property p_mreset; master_reset_in [*6] |-> drq == 4'h0; endproperty
	a_mreset:
	assert property (p_mreset) else $error("dma request raised under master reset");
	property p_ready_in_cycle; $rose(chrdy_oe) |-> !cs_n && (!ior_n || !iow_n); endproperty
	a_ready_in_cycle:
	assert property (p_ready_in_cycle) else $error("ready pulled low outside a strobe");
	property p_one_ack; $onehot0(~dack_n); endproperty
	a_one_ack:
	assert property (p_one_ack) else $error("more than one dma acknowledge");
	property p_tc_with_ack; tc |-> dack_n != 4'hF && aen; endproperty
	a_tc_with_ack:
	assert property (p_tc_with_ack) else $error("terminal count outside a dma cycle");
	property p_tc_ends; tc && !dack_n[0] |-> ##[1:10] !drq[0]; endproperty
	a_tc_ends:
	assert property (p_tc_ends) else $error("request not dropped after terminal count");
	// ============================================================
	// covers
	c_write: cover property (!iow_n && !cs_n);
	c_tc: cover property (tc);
	c_stretch: cover property (chrdy_oe [*8]);
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// ============================================================
// testbench: host and device ends joined by the interface
// assumes mclk at 100 MHz and config base 0x250
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst_n, reset_device, cmd_valid, cmd_write, cmd_ready, rsp_valid;
	logic [11:0] cmd_addr;
	logic [7:0]  cmd_wdata, rsp_rdata, irq_src, rd;
	logic [3:0]  dma_enable, dma_tc_sent, dma_req, dma_ack, dma_done, acks;
	logic [9:0]  irq_level;
	logic        device_reset, epp_mode, epp_busy, printer_detect_in, route_to_printer;
	logic        acpi_irq, external_irq_in, external_irq_seen, ir_ext, ir_sel1, ir_sel2;
	logic [1:0]  gpio_out, gpio_oe, gpio_in;
	logic        fast_ir_dir_out, fast_ir_sel0, fast_ir_pin_i, fast_ir_pin_o, fast_ir_pin_oe, fast_ir_rx;
	logic        ir_module_select1, ir_module_select2, ref_clock_select, serial_irq_mode;
	int          fails, compares, n, dn, tn;
	logic [7:0]  cfgv [4] = '{8'h00, 8'h04, 8'h01, 8'h01};
	hipm_if bus_if ();
	assign fast_ir_pin_i = fast_ir_pin_oe ? fast_ir_pin_o : ir_ext;
	hipm_host #(.DMA_LEN(2)) hipm_host_i (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .bus(bus_if.host),
		.reset_device(reset_device), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.dma_enable(dma_enable), .dma_tc_sent(dma_tc_sent), .irq_level(irq_level));
	hipm_dev hipm_dev_i (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .bus(bus_if.dev), .device_reset(device_reset),
		.epp_mode(epp_mode), .epp_busy(epp_busy), .dma_req(dma_req), .dma_ack(dma_ack), .dma_done(dma_done),
		.printer_detect_in(printer_detect_in), .route_to_printer(route_to_printer), .irq_src(irq_src),
		.acpi_irq(acpi_irq), .external_irq_in(external_irq_in), .external_irq_seen(external_irq_seen),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .fast_ir_dir_out(fast_ir_dir_out),
		.fast_ir_sel0(fast_ir_sel0), .fast_ir_pin_i(fast_ir_pin_i), .fast_ir_pin_o(fast_ir_pin_o),
		.fast_ir_pin_oe(fast_ir_pin_oe), .fast_ir_rx(fast_ir_rx), .ir_sel1(ir_sel1), .ir_sel2(ir_sel2),
		.ir_module_select1(ir_module_select1), .ir_module_select2(ir_module_select2),
		.ref_clock_select(ref_clock_select), .serial_irq_mode(serial_irq_mode));
	hipm_sva hipm_sva_i (.mclk(mclk), .rst_n(rst_n), .master_reset_in(bus_if.master_reset_in), .cs_n(bus_if.cs_n),
		.aen(bus_if.aen), .ior_n(bus_if.ior_n), .iow_n(bus_if.iow_n), .addr(bus_if.addr), .hd_oe(bus_if.hd_oe),
		.dd_oe(bus_if.dd_oe), .chrdy_oe(bus_if.chrdy_oe), .drq(bus_if.drq), .dack_n(bus_if.dack_n), .tc(bus_if.tc));
	// ============================================================
	// reporting and bus tasks
	task automatic fail(input string m);
		fails++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
		compares++;
		if (got !== exp) fail(m);
	endtask
	task automatic tend(input string m);
		$display("test %s done", m);
	endtask
	task automatic test_done;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic bus_op(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r,
		output int t);
		t = 0;
		r = 8'h00;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		do begin
			@(negedge mclk);
			t++;
		end while (cmd_ready !== 1'b1 && t < 400);
		@(posedge mclk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge mclk);
			t++;
		end while ((w ? cmd_ready : rsp_valid) !== 1'b1 && t < 400);
		r = rsp_rdata;
		if (t >= 400) fail("bus cycle hung");
		repeat (w ? 8 : 1) @(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus_op(1'b1, a, d, rd, n);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string m);
		bus_op(1'b0, a, 8'h00, rd, n);
		chk({2'b00, rd}, {2'b00, e}, m);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (60000) @(posedge mclk);
		fail("watchdog expired");
		test_done;
	end
	// ============================================================
	// main sequence
	initial begin
		{rst_n, reset_device, cmd_valid, cmd_write, epp_mode, epp_busy, acpi_irq, external_irq_in} = 8'h00;
		{fast_ir_dir_out, fast_ir_sel0, ir_ext, ir_sel1, ir_sel2, printer_detect_in} = 6'h01;
		{cmd_addr, cmd_wdata, irq_src, dma_enable, dma_req, gpio_out, gpio_oe} = 40'h0;
		fails = 0;
		compares = 0;
		wt(20);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++)
			rd_chk(12'h250 + 12'(i), 8'h00, "reset value");
		rd_chk(12'h254, 8'h80, "status after reset");
		rd_chk(12'h257, 8'h00, "unused index");
		tend("reset");
		for (int i = 1; i < 4; i++) begin
			wr(12'h250 + 12'(i), cfgv[i]);
			rd_chk(12'h250 + 12'(i), cfgv[i], "readback");
		end
		chk(10'(serial_irq_mode), 10'h1, "serial irq mode");
		chk(10'(ref_clock_select), 10'h1, "clock select");
		tn = 0;
		repeat (hipm_pkg::SIRQ_SLOTS * 2 * hipm_pkg::PCI_HALF) begin
			@(negedge mclk);
			tn += int'(irq_level[1] === 1'b0);
		end
		chk(10'(tn), 10'(2 * hipm_pkg::PCI_HALF), "serial irq start slot");
		@(posedge mclk);
		acpi_irq <= 1'b1;
		wt(10);
		chk(10'(irq_level[9:8]), 10'h1, "acpi on pin A");
		acpi_irq <= 1'b0;
		for (int i = 1; i < 4; i++)
			wr(12'h250 + 12'(i), 8'h00);
		irq_src <= 8'hFD;
		external_irq_in <= 1'b1;
		wt(10);
		chk(irq_level, 10'h1FE, "irq pins");
		chk(10'(external_irq_seen), 10'h1, "external irq");
		rd_chk(12'h254, 8'hD0, "status with irqs");
		wr(12'h250, 8'h10);
		irq_src <= 8'h02;
		gpio_oe <= 2'b11;
		gpio_out <= 2'b10;
		wt(8);
		chk(10'(irq_level[9:8]), 10'h1, "gpio on pins");
		chk(10'(gpio_in), 10'h2, "gpio input");
		tend("config and irq");
		rd_chk(12'hA51, 8'hFF, "a11 set, wide decode on");
		wr(12'h250, 8'h50);
		rd_chk(12'hA50, 8'h50, "a11 ignored");
		wr(12'h250, 8'h00);
		rd_chk(12'h260, 8'hFF, "off base");
		printer_detect_in <= 1'b0;
		wt(8);
		chk(10'(route_to_printer), 10'h1, "detect disabled");
		wr(12'h250, 8'h80);
		chk(10'(route_to_printer), 10'h0, "external floppy");
		printer_detect_in <= 1'b1;
		wt(8);
		chk(10'(route_to_printer), 10'h1, "printer");
		wr(12'h250, 8'h00);
		tend("decode and detect");
		{fast_ir_dir_out, fast_ir_sel0, ir_sel1} <= 3'b111;
		wt(4);
		chk({fast_ir_pin_oe, fast_ir_pin_o, ir_module_select1, ir_module_select2}, 10'hE, "ir out");
		{fast_ir_dir_out, ir_ext, ir_sel1, ir_sel2} <= 4'b0101;
		wt(8);
		chk({fast_ir_pin_oe, fast_ir_rx, ir_module_select1, ir_module_select2}, 10'h5, "ir in");
		epp_mode <= 1'b1;
		epp_busy <= 1'b1;
		fork
			bus_op(1'b0, 12'h250, 8'h00, rd, n);
			begin
				wt(40);
				epp_busy <= 1'b0;
			end
		join
		epp_mode <= 1'b0;
		chk(10'(n >= 40), 10'h1, "epp stretch");
		tend("ir and epp");
		dma_enable <= 4'hF;
		for (int ch = 0; ch < 4; ch++) begin
			dma_req[ch] <= 1'b1;
			{dn, tn, acks} = '0;
			repeat (300) begin
				@(negedge mclk);
				dn += int'(dma_done[ch] === 1'b1);
				tn += int'(dma_tc_sent[ch] === 1'b1);
				acks |= dma_ack;
			end
			chk(10'(dn), 10'h1, "dma done once");
			chk(10'(tn), 10'h1, "tc sent once");
			chk({acks, bus_if.drq}, 10'(1 << (ch + 4)), "ack pairs, request dropped");
			@(posedge mclk);
			dma_req[ch] <= 1'b0;
			wt(8);
		end
		tend("dma");
		wr(12'h252, 8'h01);
		reset_device <= 1'b1;
		wt(10);
		chk({device_reset, ref_clock_select}, 10'h2, "master reset");
		reset_device <= 1'b0;
		wt(10);
		rd_chk(12'h252, 8'h00, "cleared by master reset");
		tend("master reset");
		test_done;
	end
endmodule
`default_nettype wire
